// ### hw/fm_framer_consts.svh
// Purpose: constants of the single-density track format framer
// Assumes: a 10 MHz controller clock
// Notes:   definitions only
`ifndef FM_FRAMER_CONSTS_SVH
`define FM_FRAMER_CONSTS_SVH

// ============================================================
// timing
`define CLK_MHZ        10
`define CELL_NS        2000
`define CELL_CYC       (`CELL_NS * `CLK_MHZ / 1000)
`define HALF_CYC       (`CELL_CYC / 2)
`define CRC_SHOW_US    32
`define CRC_SHOW_CYC   (`CRC_SHOW_US * `CLK_MHZ)

// ============================================================
// geometry
`define TRACKS_PER_SIDE 77
`define SECTORS_PER_TRK 26
`define SECTOR_BYTES    128
`define ID_FIELD_BYTES  6
`define GAP_POST_INDEX  9'h020
`define GAP_ID          9'h011
`define GAP_DATA        9'h021
`define GAP_PRE_INDEX   9'h140

// ============================================================
// address marks and check code
`define MARK_CLK       8'hC7
`define MARK_IDX_DATA  8'hFC
`define MARK_ID_DATA   8'hFE
`define MARK_DAT_DATA  8'hFB
`define MARK_DEL_DATA  8'hF8
`define FULL_CLK       8'hFF
`define GAP_BYTE       8'h00
`define CRC_POLY       16'h1021
`define CRC_PRESET     16'hFFFF

`endif

// ### hw/fm_framer_pkg.sv
// Purpose: types shared by the track format framer
// Assumes: nothing
// Notes:   encodings follow declaration order
package fm_framer_pkg;

  typedef enum logic [2:0] {
    K_GAP,
    K_MARK,
    K_DATA,
    K_CRC,
    K_ID_TRACK,
    K_ID_SECTOR
  } wr_kind_t;

  typedef enum logic [1:0] {
    M_INDEX,
    M_ID,
    M_DATA,
    M_DELETED
  } mark_kind_t;

  typedef enum logic {
    R_HUNT,
    R_FIELD
  } rd_state_t;

endpackage

// ### hw/fm_track_format_framer.sv
// Purpose: FM track format writer and reader between byte logic and a drive
// Assumes: 10 MHz MCLK, synchronous active-low NRST, separated read clock
// Notes:   write entries pass a 4-word FIFO; read side hunts for marks
`timescale 1ns/1ns
`include "fm_framer_consts.svh"
`default_nettype none

// ============================================================
// byte fifo
module fm_byte_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic [CW-1:0]    count_nxt;
  logic             push;
  logic             pop;

  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    count_nxt = count_r;
    if (push && !pop)
      count_nxt = count_r + CW'(1);
    else if (pop && !push)
      count_nxt = count_r - CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      count_r  <= count_nxt;
      // registered so the source sees an honest, glitch-free full
      in_ready <= (count_nxt != CW'(DEPTH));
    end
  end
endmodule // fm_byte_fifo

// ============================================================
// framer top
module fm_track_format_framer
  import fm_framer_pkg::*;
#(
  parameter int TRACKS  = `TRACKS_PER_SIDE,
  parameter int SECTORS = `SECTORS_PER_TRK,
  parameter int SEC_LEN = `SECTOR_BYTES,
  parameter int DEPTH   = 4
) (
  input  wire logic       MCLK,
  input  wire logic       NRST,
  input  wire logic [7:0] WR_BYTE,
  input  wire logic [2:0] WR_KIND,
  input  wire logic       WR_VALID,
  output logic            WR_READY,
  output logic            WGATE,
  output logic            WDATA,
  output logic            FMT_ERR,
  input  wire logic       RCLK,
  input  wire logic       RDATA,
  output logic [7:0]      RD_BYTE,
  output logic            RD_VALID,
  output logic            RD_MARK,
  output logic [1:0]      RD_MARK_KIND,
  output logic            RD_IN_FIELD,
  output logic            CRC_OK,
  output logic            CRC_BAD
);
  localparam logic [4:0] CELL_LAST = 5'(`CELL_CYC - 1);
  localparam logic [4:0] HALF_AT   = 5'(`HALF_CYC);
  localparam logic [8:0] SHOW_CYC  = 9'(`CRC_SHOW_CYC);

  // ============================================================
  // helpers
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb)
        r = r ^ `CRC_POLY;
    end
    return r;
  endfunction

  function automatic logic [7:0] mark_data(input logic [1:0] k);
    case (mark_kind_t'(k))
      M_INDEX: return `MARK_IDX_DATA;
      M_ID:    return `MARK_ID_DATA;
      M_DATA:  return `MARK_DAT_DATA;
      default: return `MARK_DEL_DATA;
    endcase
  endfunction

  // clock bit then data bit per cell, most significant cell first
  function automatic logic [15:0] fm_pair(input logic [7:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[2*i+1] = c[i];
      r[2*i]   = d[i];
    end
    return r;
  endfunction

  function automatic logic [7:0] data_of(input logic [15:0] raw);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i] = raw[2*i];
    return r;
  endfunction

  function automatic logic [8:0] gap_len(input logic [1:0] sel);
    case (sel)
      2'h0:    return `GAP_POST_INDEX;
      2'h1:    return `GAP_ID;
      2'h2:    return `GAP_DATA;
      default: return `GAP_PRE_INDEX;
    endcase
  endfunction

  // ============================================================
  // write entry fifo
  logic [10:0] f_data;
  logic        f_valid;
  logic        f_pop;
  wr_kind_t    f_kind;
  logic [7:0]  f_byte;

  fm_byte_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_fifo (
    .clk       (MCLK),
    .rst_n     (NRST),
    .in_data   ({WR_KIND, WR_BYTE}),
    .in_valid  (WR_VALID),
    .in_ready  (WR_READY),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );
  assign f_kind = wr_kind_t'(f_data[10:8]);
  assign f_byte = f_data[7:0];

  // ============================================================
  // write byte selection
  logic        w_busy_r;
  logic [4:0]  cell_r;
  logic [2:0]  bit_r;
  logic [7:0]  sh_d_r;
  logic [7:0]  sh_c_r;
  logic [8:0]  gap_left_r;
  logic        pend_v_r;
  logic [7:0]  pend_r;
  logic        pend_crc_r;
  logic [15:0] wcrc_r;
  logic        byte_end;
  logic        ld;
  logic [7:0]  ld_d;
  logic [7:0]  ld_c;
  logic        ld_upd;
  logic        ld_mark;

  assign byte_end = w_busy_r && (cell_r == CELL_LAST) && (bit_r == 3'h7);

  always_comb
  begin
    ld      = 1'b0;
    ld_d    = `GAP_BYTE;
    ld_c    = `FULL_CLK;
    ld_upd  = 1'b0;
    ld_mark = 1'b0;
    f_pop   = 1'b0;
    if (!w_busy_r || byte_end)
    begin
      if (gap_left_r != 9'h000)
        ld = 1'b1;
      else if (pend_v_r)
      begin
        ld     = 1'b1;
        ld_d   = pend_r;
        ld_upd = pend_crc_r;
      end
      else if (f_valid)
      begin
        ld    = 1'b1;
        f_pop = 1'b1;
        case (f_kind)
          K_GAP:  ld_d = `GAP_BYTE;
          K_MARK:
          begin
            ld_d    = mark_data(f_byte[1:0]);
            ld_c    = `MARK_CLK;
            ld_mark = 1'b1;
          end
          K_CRC:  ld_d = wcrc_r[15:8];
          default:
          begin
            ld_d   = f_byte;
            ld_upd = 1'b1;
          end
        endcase
      end
    end
  end

  // gap counting and the byte that follows a paired entry
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      gap_left_r <= 9'h000;
      pend_v_r   <= 1'b0;
      pend_r     <= 8'h00;
      pend_crc_r <= 1'b0;
    end
    else if (ld)
    begin
      if (f_pop && f_kind == K_GAP)
        gap_left_r <= gap_len(f_byte[1:0]) - 9'h001;
      else if (gap_left_r != 9'h000)
        gap_left_r <= gap_left_r - 9'h001;
      if (f_pop && f_kind == K_CRC)
      begin
        pend_v_r   <= 1'b1;
        pend_r     <= wcrc_r[7:0];
        pend_crc_r <= 1'b0;
      end
      else if (f_pop && (f_kind == K_ID_TRACK || f_kind == K_ID_SECTOR))
      begin
        pend_v_r   <= 1'b1;
        pend_r     <= `GAP_BYTE;
        pend_crc_r <= 1'b1;
      end
      else if (!f_pop && gap_left_r == 9'h000)
        pend_v_r <= 1'b0;
    end
  end

  // write check code; preset on every mark
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
      wcrc_r <= `CRC_PRESET;
    else if (ld && ld_mark)
      wcrc_r <= crc_byte(`CRC_PRESET, ld_d);
    else if (ld && ld_upd)
      wcrc_r <= crc_byte(wcrc_r, ld_d);
  end

  // out-of-range ID values are still written, only flagged
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
      FMT_ERR <= 1'b0;
    else
      FMT_ERR <= f_pop && (
        (f_kind == K_ID_TRACK && 32'(f_byte) >= TRACKS) ||
        (f_kind == K_ID_SECTOR && (f_byte == 8'h00 || 32'(f_byte) > SECTORS)));
  end

  // ============================================================
  // fm serializer
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      w_busy_r <= 1'b0;
      cell_r   <= 5'h00;
      bit_r    <= 3'h0;
      sh_d_r   <= 8'h00;
      sh_c_r   <= 8'h00;
    end
    else if (ld)
    begin
      w_busy_r <= 1'b1;
      cell_r   <= 5'h00;
      bit_r    <= 3'h0;
      sh_d_r   <= ld_d;
      sh_c_r   <= ld_c;
    end
    else if (w_busy_r)
    begin
      if (cell_r == CELL_LAST)
      begin
        cell_r <= 5'h00;
        bit_r  <= bit_r + 3'h1;
        sh_d_r <= {sh_d_r[6:0], 1'b0};
        sh_c_r <= {sh_c_r[6:0], 1'b0};
        if (bit_r == 3'h7)
          w_busy_r <= 1'b0;
      end
      else
        cell_r <= cell_r + 5'h01;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      WDATA <= 1'b0;
      WGATE <= 1'b0;
    end
    else
    begin
      WDATA <= w_busy_r && ((cell_r == 5'h00 && sh_c_r[7]) ||
                            (cell_r == HALF_AT && sh_d_r[7]));
      WGATE <= w_busy_r;
    end
  end

  // ============================================================
  // read input synchronisers
  logic rclk_m_r;
  logic rclk_s_r;
  logic rclk_d_r;
  logic rdat_m_r;
  logic rdat_s_r;
  logic rise;

  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      rclk_m_r <= 1'b0;
      rclk_s_r <= 1'b0;
      rclk_d_r <= 1'b0;
      rdat_m_r <= 1'b0;
      rdat_s_r <= 1'b0;
    end
    else
    begin
      rclk_m_r <= RCLK;
      rclk_s_r <= rclk_m_r;
      rclk_d_r <= rclk_s_r;
      rdat_m_r <= RDATA;
      rdat_s_r <= rdat_m_r;
    end
  end
  assign rise = rclk_s_r && !rclk_d_r;

  // ============================================================
  // read framing
  rd_state_t   rstate_r;
  logic [15:0] raw_r;
  logic [15:0] raw_nxt;
  logic [3:0]  half_r;
  logic [7:0]  left_r;
  logic [15:0] rcrc_r;
  logic [15:0] rcrc_nxt;
  logic [7:0]  rbyte;
  logic        hit;
  logic [1:0]  hit_kind;
  logic        byte_done;
  logic        field_end;

  assign raw_nxt   = {raw_r[14:0], rdat_s_r};
  assign rbyte     = data_of(raw_nxt);
  assign rcrc_nxt  = crc_byte(rcrc_r, rbyte);
  assign byte_done = rise && rstate_r == R_FIELD && half_r == 4'hF;
  assign field_end = byte_done && left_r == 8'h01;

  always_comb
  begin
    hit      = 1'b0;
    hit_kind = 2'h0;
    for (int k = 0; k < 4; k++)
      if (raw_nxt == fm_pair(`MARK_CLK, mark_data(2'(k))))
      begin
        hit      = 1'b1;
        hit_kind = 2'(k);
      end
  end

  // gaps are never counted, so drift after rewrites is harmless
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      rstate_r <= R_HUNT;
      raw_r    <= 16'h0000;
      half_r   <= 4'h0;
      left_r   <= 8'h00;
      rcrc_r   <= `CRC_PRESET;
    end
    else if (rise)
    begin
      raw_r <= raw_nxt;
      case (rstate_r)
        R_HUNT:
          if (hit && mark_kind_t'(hit_kind) != M_INDEX)
          begin
            rstate_r <= R_FIELD;
            half_r   <= 4'h0;
            rcrc_r   <= crc_byte(`CRC_PRESET, mark_data(hit_kind));
            left_r   <= (mark_kind_t'(hit_kind) == M_ID) ?
                        8'(`ID_FIELD_BYTES) : 8'(SEC_LEN + 2);
          end
        R_FIELD:
        begin
          half_r <= half_r + 4'h1;
          if (half_r == 4'hF)
          begin
            rcrc_r <= rcrc_nxt;
            left_r <= left_r - 8'h01;
            if (left_r == 8'h01)
              rstate_r <= R_HUNT;
          end
        end
        default: rstate_r <= R_HUNT;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      RD_BYTE      <= 8'h00;
      RD_VALID     <= 1'b0;
      RD_MARK      <= 1'b0;
      RD_MARK_KIND <= 2'h0;
      RD_IN_FIELD  <= 1'b0;
    end
    else
    begin
      RD_VALID    <= byte_done;
      RD_MARK     <= rise && rstate_r == R_HUNT && hit;
      RD_IN_FIELD <= (rstate_r == R_FIELD);
      if (byte_done)
        RD_BYTE <= rbyte;
      if (rise && rstate_r == R_HUNT && hit)
        RD_MARK_KIND <= hit_kind;
    end
  end

  // ============================================================
  // check result window
  logic [8:0] show_r;

  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      show_r  <= 9'h000;
      CRC_OK  <= 1'b0;
      CRC_BAD <= 1'b0;
    end
    else if (field_end)
    begin
      show_r  <= SHOW_CYC;
      CRC_OK  <= (rcrc_nxt == 16'h0000);
      CRC_BAD <= (rcrc_nxt != 16'h0000);
    end
    else if (show_r != 9'h000)
    begin
      show_r <= show_r - 9'h001;
      if (show_r == 9'h001)
      begin
        CRC_OK  <= 1'b0;
        CRC_BAD <= 1'b0;
      end
    end
  end
endmodule // fm_track_format_framer

`default_nettype wire

// ### bench/fm_track_format_framer_props.sv
// Purpose: port assertions for the FM track format framer
// Assumes: one clock domain, MCLK, synchronous active-low NRST
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// checker
module fm_framer_props (
  input wire logic       MCLK,
  input wire logic       NRST,
  input wire logic       WGATE,
  input wire logic       WDATA,
  input wire logic       FMT_ERR,
  input wire logic       RD_VALID,
  input wire logic       RD_MARK,
  input wire logic [1:0] RD_MARK_KIND,
  input wire logic       RD_IN_FIELD,
  input wire logic       CRC_OK,
  input wire logic       CRC_BAD
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  logic [9:0] show_r;
  // length of the current result window
  always_ff @(posedge MCLK)
  begin
    if (!NRST || !(CRC_OK || CRC_BAD))
      show_r <= 10'h000;
    else
      show_r <= show_r + 10'h001;
  end
  // eight quiet cycles; the ninth is stepped on its own
  sequence s_quiet;
    !WDATA [*8];
  endsequence
  property p_pulse_gap;
    WDATA |=> s_quiet ##1 !WDATA;
  endproperty
  property p_cell_fill;
    (WDATA && WGATE) |=> s_quiet ##[2:14] (WDATA || !WGATE);
  endproperty
  property p_idle_quiet;
    (!WGATE && !$past(WGATE) && !$past(WGATE, 2)) |-> !WDATA;
  endproperty
  property p_err_pulse;
    FMT_ERR |=> !FMT_ERR;
  endproperty
  property p_rd_strobe;
    RD_VALID |=> !RD_VALID [*8];
  endproperty
  property p_hunt_only;
    RD_MARK |-> !$past(RD_IN_FIELD);
  endproperty
  property p_index_nofield;
    (RD_MARK && RD_MARK_KIND == 2'h0) |=> !RD_IN_FIELD;
  endproperty
  property p_kind_hold;
    !RD_MARK |-> $stable(RD_MARK_KIND);
  endproperty
  property p_crc_excl;
    !(CRC_OK && CRC_BAD);
  endproperty
  property p_show_len;
    ($past(CRC_OK || CRC_BAD) && !(CRC_OK || CRC_BAD)) |-> show_r == 10'h140;
  endproperty
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("write pulses closer than half a cell");
  a_cell_fill: assert property (p_cell_fill)
    else $error("written cell without any pulse");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("write pulse outside the gate");
  a_err_pulse: assert property (p_err_pulse)
    else $error("format error longer than one cycle");
  a_rd_strobe: assert property (p_rd_strobe)
    else $error("read bytes too close");
  a_hunt_only: assert property (p_hunt_only)
    else $error("mark reported inside a field");
  a_index_nofield: assert property (p_index_nofield)
    else $error("index mark opened a field");
  a_kind_hold: assert property (p_kind_hold)
    else $error("mark kind changed without a mark");
  a_crc_excl: assert property (p_crc_excl)
    else $error("check good and bad together");
  a_show_len: assert property (p_show_len)
    else $error("check result window length wrong");
endmodule // fm_framer_props

bind fm_track_format_framer fm_framer_props u_props (
  .MCLK        (MCLK),
  .NRST        (NRST),
  .WGATE       (WGATE),
  .WDATA       (WDATA),
  .FMT_ERR     (FMT_ERR),
  .RD_VALID    (RD_VALID),
  .RD_MARK     (RD_MARK),
  .RD_MARK_KIND(RD_MARK_KIND),
  .RD_IN_FIELD (RD_IN_FIELD),
  .CRC_OK      (CRC_OK),
  .CRC_BAD     (CRC_BAD)
);
`default_nettype wire

// ### bench/fm_drive_model.sv
// Purpose: drive model: records write pulses, plays read half cells
// Assumes: write slots every 10 MCLK from the first pulse on
// Notes:   read clock stands still between frames
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// drive
module fm_drive_model (
  input  wire logic mclk,
  input  wire logic wdata,
  output logic      rclk,
  output logic      rdata
);
  logic got[$];
  int   t;
  int   t0;
  int   stray;
  bit   playing;
  initial
  begin
    rclk = 1'b0;
    rdata = 1'b0;
    playing = 1'b0;
    t0 = -1;
    t = 0;
    stray = 0;
  end
  // idle line wanders so a stale level is never trusted
  always @(posedge mclk)
  begin
    if (!playing)
      rdata <= ~rdata;
  end
  always @(negedge mclk)
  begin
    if (t0 < 0 && wdata === 1'b1)
      t0 = t;
    if (t0 >= 0 && (t - t0) % 10 == 0)
      got.push_back(wdata);
    else if (wdata === 1'b1)
      stray++;
    t++;
  end
  task automatic clear();
    got.delete();
    t0 = -1;
    stray = 0;
  endtask
  task automatic frame(input logic h[$]);
    playing = 1'b1;
    #37;
    foreach (h[i])
    begin
      rdata = h[i];
      #400 rclk = 1'b1;
      #400 rclk = 1'b0;
    end
    playing = 1'b0;
  endtask
endmodule // fm_drive_model
`default_nettype wire

// ### bench/fm_track_format_framer_tb.sv
// Purpose: self-checking bench for the FM track format framer
// Assumes: 10 MHz MCLK, drive model on the serial side
// Notes:   write stream and read fields checked against queue models
`timescale 1ns/1ns
`include "fm_framer_consts.svh"
`default_nettype none
module fm_track_format_framer_tb import fm_framer_pkg::*;;
  logic       mclk;
  logic       nrst;
  logic [7:0] wr_byte;
  logic [2:0] wr_kind;
  logic       wr_valid;
  logic       wr_ready;
  logic       wgate;
  logic       wdata;
  logic       fmt_err;
  logic       rclk;
  logic       rdata;
  logic [7:0] rd_byte;
  logic       rd_valid;
  logic       rd_mark;
  logic [1:0] rd_kind;
  logic       rd_field;
  logic       crc_ok;
  logic       crc_bad;
  int         failures;
  int         n_compared;
  int         cycles;
  int         n_err;
  logic [31:0] seed;
  logic [15:0] crc;
  logic [7:0] trk;
  logic [7:0] sec;
  logic       exp[$];
  logic [7:0] dq[$];
  logic [7:0] rd_got[$];
  logic [1:0] mk_got[$];
  logic [7:0] mdat[4];
  int         glen[4];

  fm_track_format_framer DUT (.MCLK(mclk), .NRST(nrst), .WR_BYTE(wr_byte),
    .WR_KIND(wr_kind), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WGATE(wgate),
    .WDATA(wdata), .FMT_ERR(fmt_err), .RCLK(rclk), .RDATA(rdata), .RD_BYTE(rd_byte),
    .RD_VALID(rd_valid), .RD_MARK(rd_mark), .RD_MARK_KIND(rd_kind),
    .RD_IN_FIELD(rd_field), .CRC_OK(crc_ok), .CRC_BAD(crc_bad));
  fm_drive_model drv (.mclk(mclk), .wdata(wdata), .rclk(rclk), .rdata(rdata));

  // ============================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] cupd(input logic [15:0] c, input logic [7:0] b);
    logic fb;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", what, want, seen);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic put(ref logic q[$], input logic [7:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      q.push_back(c[i]);
      q.push_back(d[i]);
    end
  endtask
  // offer one entry, wait while the fifo is full
  task automatic emit(input logic [2:0] k, input logic [7:0] b);
    wr_kind = k;
    wr_byte = b;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1)
      @(negedge mclk);
    @(negedge mclk);
    case (k)
      K_GAP: repeat (glen[b[1:0]]) put(exp, 8'hFF, 8'h00);
      K_MARK:
      begin
        crc = 16'hFFFF;
        put(exp, `MARK_CLK, mdat[b[1:0]]);
        crc = cupd(crc, mdat[b[1:0]]);
      end
      K_CRC:
      begin
        put(exp, 8'hFF, crc[15:8]);
        put(exp, 8'hFF, crc[7:0]);
      end
      K_ID_TRACK, K_ID_SECTOR:
      begin
        put(exp, 8'hFF, b);
        put(exp, 8'hFF, 8'h00);
        crc = cupd(cupd(crc, b), 8'h00);
      end
      default:
      begin
        put(exp, 8'hFF, b);
        crc = cupd(crc, b);
      end
    endcase
  endtask
  task automatic wait_write();
    int quiet;
    quiet = 0;
    wr_valid = 1'b0;
    while (quiet < 40)
    begin
      @(negedge mclk);
      quiet = (wgate === 1'b0) ? quiet + 1 : 0;
    end
  endtask
  task automatic rd_frame(input int k, input logic [7:0] d[$], input bit spoil);
    logic        h[$];
    logic [15:0] c;
    c = cupd(16'hFFFF, mdat[k]);
    foreach (d[i])
      c = cupd(c, d[i]);
    d.push_back(c[15:8]);
    d.push_back(c[7:0] ^ {7'h00, spoil});
    repeat (2) put(h, 8'hFF, 8'h00);
    put(h, `MARK_CLK, mdat[k]);
    if (k != 0)
      foreach (d[i])
        put(h, 8'hFF, d[i]);
    rd_got.delete();
    mk_got.delete();
    drv.frame(h);
    repeat (12) @(negedge mclk);
    check("marks", mk_got.size(), 1);
    check("mark kind", mk_got[0], k);
    check("in field", rd_field, 0);
    check("bytes", rd_got.size(), (k != 0) ? d.size() : 0);
    if (k != 0)
    begin
      foreach (d[i])
        check("read byte", rd_got[i], d[i]);
      check("check good", crc_ok, !spoil);
      check("check bad", crc_bad, spoil);
    end
  endtask

  // ============================================================
  // clock, monitors, timeout
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(negedge mclk)
  begin
    cycles++;
    if (rd_valid === 1'b1)
      rd_got.push_back(rd_byte);
    if (rd_mark === 1'b1)
      mk_got.push_back(rd_kind);
    if (fmt_err === 1'b1)
      n_err++;
    if (cycles == 90000)
    begin
      failures++;
      final_report();
    end
  end

  // ============================================================
  // main sequence
  initial
  begin
    nrst = 1'b0;
    wr_byte = 8'h00;
    wr_kind = 3'h0;
    wr_valid = 1'b0;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    n_err = 0;
    seed = 32'h0FBD;
    mdat = '{`MARK_IDX_DATA, `MARK_ID_DATA, `MARK_DAT_DATA, `MARK_DEL_DATA};
    glen = '{32, 17, 33, 320};
    repeat (5) @(negedge mclk);
    check("ready in reset", wr_ready, 0);
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
    trk = 8'(rnd() % 77);
    sec = 8'(rnd() % 26 + 1);
    drv.clear();
    emit(K_MARK, 8'h00);
    emit(K_GAP, 8'h00);
    emit(K_MARK, 8'h01);
    emit(K_ID_TRACK, trk);
    emit(K_ID_SECTOR, sec);
    emit(K_CRC, 8'h00);
    emit(K_GAP, 8'h01);
    emit(K_MARK, 8'h03);
    repeat (2) emit(K_DATA, 8'(rnd()));
    emit(K_CRC, 8'h00);
    emit(K_MARK, 8'h02);
    emit(K_DATA, 8'(rnd()));
    emit(K_CRC, 8'h00);
    wait_write();
    check("stray pulses", drv.stray, 0);
    check("cell count", drv.got.size() >= exp.size(), 1);
    foreach (exp[i])
      check("write cell", drv.got[i], exp[i]);
    n_err = 0;
    emit(K_ID_TRACK, 8'h4D);
    emit(K_ID_TRACK, 8'h4C);
    emit(K_ID_SECTOR, 8'h00);
    emit(K_ID_SECTOR, 8'h01);
    emit(K_ID_SECTOR, 8'h1A);
    emit(K_ID_SECTOR, 8'h1B);
    wait_write();
    check("format errors", n_err, 3);
    rd_frame(0, '{}, 1'b0);
    rd_frame(1, '{trk, 8'h00, sec, 8'h00}, 1'b0);
    repeat (128) dq.push_back(8'(rnd()));
    rd_frame(2, dq, 1'b0);
    rd_frame(3, dq, 1'b1);
    final_report();
  end
endmodule // fm_track_format_framer_tb
`default_nettype wire
